/* include/ampctl_pkg.sv */
// Package for the amplifier control and override logic: map, fields, codes, carriers
package ampctl_pkg;

	// ==========================================================
	// Register map (one word apart on the bus, byte addresses)
	localparam logic [3:0] ADDR_CONTROL    = 4'h0;
	localparam logic [3:0] ADDR_OVR_SOURCE = 4'h4;
	localparam logic [3:0] ADDR_INV_CHAN   = 4'h8;
	localparam logic [3:0] ADDR_NONINV_CH  = 4'hc;

	// ==========================================================
	// Field positions and write masks
	localparam int unsigned CTL_ENABLE_BIT   = 7;
	localparam int unsigned CTL_UNITY_BIT    = 4;
	localparam int unsigned CTL_POLARITY_BIT = 2;
	localparam logic [7:0]  CTL_WMASK        = 8'h97;
	localparam logic [7:0]  ORS_WMASK        = 8'h1f;
	localparam logic [7:0]  CHS_WMASK        = 8'h0f;
	localparam logic [7:0]  RESET_VALUE      = 8'h00;

	// ==========================================================
	// Override modes
	typedef enum logic [1:0] {
		OVR_NONE     = 2'b00,
		OVR_TRISTATE = 2'b01,
		OVR_UNITY    = 2'b10,
		OVR_RESERVED = 2'b11
	} ampctl_mode_t;

	// Override source code ranges
	localparam logic [4:0] ORS_CMP_FIRST  = 5'h0c;
	localparam logic [4:0] ORS_CMP_LAST   = 5'h11;
	localparam logic [4:0] ORS_CELL_FIRST = 5'h14;
	localparam logic [4:0] ORS_CELL_LAST  = 5'h17;
	localparam logic [4:0] ORS_GEN_A      = 5'h18;
	localparam logic [4:0] ORS_GEN_B      = 5'h1c;

	// Channel codes, largest legal code for instances 1 and 2
	localparam logic [3:0] CH_LAST_LEGAL  = 4'h8;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [2:0] capture_compare_output;       // units 1..3
		logic [5:0] pulse_width_output;           // 3,4,9,5,6,11
		logic [5:0] synced_comparator_output;     // comparators 1..6
		logic [3:0] logic_cell_output;            // cells 1..4
		logic [3:0] complementary_generator_a;    // gen 1 (gen 3 on inst 3), A..D
		logic [3:0] complementary_generator_b;    // gen 2, A..D
	} ampctl_sources_t;

	typedef struct packed {
		logic       enable;
		logic       unity_gain_switch;
		logic       output_hiz;
		logic [8:0] inverting_select;     // one-hot analog mux select
		logic [8:0] noninverting_select;
		logic       inverting_pin_release;
	} ampctl_analog_t;

endpackage

/* hw/ampctl_top.sv */
// Digital control, channel select and output override for one on-chip amplifier
`timescale 1ns/1ps

module ampctl_top #(
	parameter int unsigned INSTANCE = 1
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        sleep_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [3:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	output logic                             wb_err_o,
	input  wire ampctl_pkg::ampctl_sources_t src_i,
	output ampctl_pkg::ampctl_analog_t       analog_o,
	output logic                             override_active_o
);

	// ==========================================================
	// Register state
	logic [7:0] control_q;
	logic [7:0] ovr_source_q;
	logic [7:0] inv_chan_q;
	logic [7:0] noninv_chan_q;
	logic       ack_q;
	logic       err_q;
	logic [31:0] rdata_q;

	logic       req;
	logic       wr_en;
	logic       addr_hit;
	logic       src_raw;
	logic       ovr_true;
	logic       ovr_act;
	ampctl_pkg::ampctl_mode_t mode;

	// One-hot decode of a channel code for this instance; reserved codes give no switch
	function automatic logic [8:0] chan_decode(input logic [3:0] code);
		logic [8:0] r;
		r = 9'h000;
		if (INSTANCE == 3) begin
			case (code)
				4'h0, 4'h2, 4'h4, 4'h6, 4'h7: r[code] = 1'b1;
				default: r = 9'h000;
			endcase
		end else if (code <= ampctl_pkg::CH_LAST_LEGAL) begin
			r[code] = 1'b1;
		end
		return r;
	endfunction

	// Is this a known register address
	function automatic logic addr_known(input logic [3:0] a);
		return (a == ampctl_pkg::ADDR_CONTROL) || (a == ampctl_pkg::ADDR_OVR_SOURCE) ||
			(a == ampctl_pkg::ADDR_INV_CHAN) || (a == ampctl_pkg::ADDR_NONINV_CH);
	endfunction

	// ==========================================================
	// Bus decode; single-cycle answer, ack dropped after one cycle
	assign req      = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	assign addr_hit = addr_known(wb_adr_i);
	assign wr_en    = req && wb_we_i && addr_hit && wb_sel_i[0];

	// Answer flags: ack for mapped, err for unmapped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ack_q <= req && addr_hit;
			err_q <= req && !addr_hit;
		end
	end

	// Control register; unimplemented bits masked off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_q <= ampctl_pkg::RESET_VALUE;
		end else if (wr_en && wb_adr_i == ampctl_pkg::ADDR_CONTROL) begin
			control_q <= wb_dat_i[7:0] & ampctl_pkg::CTL_WMASK;
		end
	end

	// Override source register; warm reset also clears, a safe reading of unknown
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_source_q <= ampctl_pkg::RESET_VALUE;
		end else if (wr_en && wb_adr_i == ampctl_pkg::ADDR_OVR_SOURCE) begin
			ovr_source_q <= wb_dat_i[7:0] & ampctl_pkg::ORS_WMASK;
		end
	end

	// Channel select registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inv_chan_q    <= ampctl_pkg::RESET_VALUE;
			noninv_chan_q <= ampctl_pkg::RESET_VALUE;
		end else if (wr_en) begin
			if (wb_adr_i == ampctl_pkg::ADDR_INV_CHAN) begin
				inv_chan_q <= wb_dat_i[7:0] & ampctl_pkg::CHS_WMASK;
			end
			if (wb_adr_i == ampctl_pkg::ADDR_NONINV_CH) begin
				noninv_chan_q <= wb_dat_i[7:0] & ampctl_pkg::CHS_WMASK;
			end
		end
	end

	// Read data, registered with the ack; zeros in all unused bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			case (wb_adr_i)
				ampctl_pkg::ADDR_CONTROL:    rdata_q <= {24'h00_0000, control_q};
				ampctl_pkg::ADDR_OVR_SOURCE: rdata_q <= {24'h00_0000, ovr_source_q};
				ampctl_pkg::ADDR_INV_CHAN:   rdata_q <= {24'h00_0000, inv_chan_q};
				ampctl_pkg::ADDR_NONINV_CH:  rdata_q <= {24'h00_0000, noninv_chan_q};
				default:                     rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdata_q;

	// ==========================================================
	// Override source mux; reserved codes read as low
	always_comb begin
		src_raw = 1'b0;
		if (ovr_source_q[4:0] <= 5'h02) begin
			src_raw = src_i.capture_compare_output[ovr_source_q[1:0]];
		end else if (ovr_source_q[4:0] >= 5'h04 && ovr_source_q[4:0] <= 5'h0a && ovr_source_q[1:0] != 2'b11) begin
			// Pulse width outputs packed 3,4,9 then 5,6,11
			src_raw = src_i.pulse_width_output[{1'b0, ovr_source_q[3], ovr_source_q[3]} + {1'b0, ovr_source_q[1:0]}];
		end else if (ovr_source_q[4:0] >= ampctl_pkg::ORS_CMP_FIRST && ovr_source_q[4:0] <= ampctl_pkg::ORS_CMP_LAST) begin
			src_raw = src_i.synced_comparator_output[3'(ovr_source_q[4:0] - ampctl_pkg::ORS_CMP_FIRST)];
		end else if (ovr_source_q[4:0] >= ampctl_pkg::ORS_CELL_FIRST && ovr_source_q[4:0] <= ampctl_pkg::ORS_CELL_LAST) begin
			src_raw = src_i.logic_cell_output[ovr_source_q[1:0]];
		end else if (ovr_source_q[4:0] >= ampctl_pkg::ORS_GEN_A && ovr_source_q[4:0] < ampctl_pkg::ORS_GEN_B) begin
			src_raw = src_i.complementary_generator_a[ovr_source_q[1:0]];
		end else if (ovr_source_q[4:0] >= ampctl_pkg::ORS_GEN_B && INSTANCE != 3) begin
			src_raw = src_i.complementary_generator_b[ovr_source_q[1:0]];
		end
	end

	// ==========================================================
	// Override qualification; purely combinational so it keeps working with clocks gated in sleep
	assign mode     = ampctl_pkg::ampctl_mode_t'(control_q[1:0]);
	assign ovr_true = control_q[ampctl_pkg::CTL_POLARITY_BIT] ? src_raw : !src_raw;
	// Reserved mode treated as none, the safe choice
	assign ovr_act  = ovr_true && (mode == ampctl_pkg::OVR_UNITY || mode == ampctl_pkg::OVR_TRISTATE);
	assign override_active_o = ovr_act && control_q[ampctl_pkg::CTL_ENABLE_BIT];

	// Analog controls
	always_comb begin
		analog_o.enable            = control_q[ampctl_pkg::CTL_ENABLE_BIT];
		analog_o.unity_gain_switch = control_q[ampctl_pkg::CTL_UNITY_BIT] ||
			(ovr_act && mode == ampctl_pkg::OVR_UNITY);
		analog_o.output_hiz        = !control_q[ampctl_pkg::CTL_ENABLE_BIT] ||
			(ovr_act && mode == ampctl_pkg::OVR_TRISTATE);
		// Pin freed when unity gain selected, so mux opens the inverting pin path
		analog_o.inverting_pin_release = control_q[ampctl_pkg::CTL_UNITY_BIT];
		analog_o.inverting_select    = control_q[ampctl_pkg::CTL_UNITY_BIT] ? 9'h000 :
			chan_decode(inv_chan_q[3:0]);
		analog_o.noninverting_select = chan_decode(noninv_chan_q[3:0]);
	end

	// ==========================================================
	// Checks
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
	a_ctl_read_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		(control_q & ~ampctl_pkg::CTL_WMASK) == 8'h00) else $error("control reserved bits set");
	a_ors_read_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[7:5] == 3'b000) else $error("source reserved bits set");
	a_hiz_when_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!control_q[ampctl_pkg::CTL_ENABLE_BIT] |-> analog_o.output_hiz) else $error("drive while disabled");
	a_mode_none_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		control_q[1:0] == 2'b00 |-> !ovr_act) else $error("override in mode none");
	a_unity_forced: assert property (@(posedge clk_i) disable iff (rst_i)
		(control_q[1:0] == 2'b10 && ovr_true) |-> analog_o.unity_gain_switch) else $error("unity not forced");
	a_tristate_forced: assert property (@(posedge clk_i) disable iff (rst_i)
		(control_q[1:0] == 2'b01 && ovr_true) |-> analog_o.output_hiz) else $error("output not tristated");
	a_polarity_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(control_q[2] && control_q[1:0] == 2'b10 && !src_raw && !control_q[4]) |-> !analog_o.unity_gain_switch)
		else $error("override on wrong level");
	a_write_control: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_adr_i == ampctl_pkg::ADDR_CONTROL) |=> control_q == ($past(wb_dat_i[7:0]) & ampctl_pkg::CTL_WMASK))
		else $error("control write lost");
	a_reset_disables: assert property (@(posedge clk_i)
		$past(rst_i) |-> !analog_o.enable) else $error("enabled after reset");

	// ==========================================================
	// Bus answer sequences; each accepted request gets exactly one pulse
	sequence s_taken_mapped;
		req && addr_hit;
	endsequence

	sequence s_taken_unmapped;
		req && !addr_hit;
	endsequence

	sequence s_ack_pulse;
		wb_ack_o && !wb_err_o ##1 !wb_ack_o;
	endsequence

	sequence s_err_pulse;
		wb_err_o && !wb_ack_o ##1 !wb_err_o;
	endsequence

	// Mapped requests answer ack, others err, one cycle later
	a_mapped_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		s_taken_mapped |=> s_ack_pulse)
		else $error("mapped access not acked");

	a_unmapped_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		s_taken_unmapped |=> s_err_pulse)
		else $error("unmapped access not refused");

	a_answer_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wb_ack_o && wb_err_o))
		else $error("ack and err together");

	// ==========================================================
	// Register writes and reads
	a_source_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_adr_i == ampctl_pkg::ADDR_OVR_SOURCE) |=>
		ovr_source_q == ($past(wb_dat_i[7:0]) & ampctl_pkg::ORS_WMASK))
		else $error("source write lost");

	a_inv_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_adr_i == ampctl_pkg::ADDR_INV_CHAN) |=>
		inv_chan_q == ($past(wb_dat_i[7:0]) & ampctl_pkg::CHS_WMASK))
		else $error("inverting select write lost");

	a_noninv_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_adr_i == ampctl_pkg::ADDR_NONINV_CH) |=>
		noninv_chan_q == ($past(wb_dat_i[7:0]) & ampctl_pkg::CHS_WMASK))
		else $error("noninverting select write lost");

	// Byte lane off means the register keeps its value
	a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && !wb_sel_i[0]) |=>
		($stable(control_q) && $stable(ovr_source_q) && $stable(inv_chan_q) && $stable(noninv_chan_q)))
		else $error("write landed with lane off");

	a_read_inv: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ampctl_pkg::ADDR_INV_CHAN) |=>
		wb_dat_o == {24'h00_0000, $past(inv_chan_q)})
		else $error("inverting select read wrong");

	a_chan_masks: assert property (@(posedge clk_i) disable iff (rst_i)
		(inv_chan_q[7:4] == 4'h0) && (noninv_chan_q[7:4] == 4'h0))
		else $error("channel reserved bits set");

	// Checked on the first edge out of reset, so no disable here
	a_reset_clears: assert property (@(posedge clk_i)
		($past(rst_i) && !rst_i) |-> ((control_q | ovr_source_q | inv_chan_q | noninv_chan_q) == 8'h00))
		else $error("register not cleared by reset");

	// ==========================================================
	// Analog controls against the control fields
	a_enable_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		analog_o.enable == control_q[ampctl_pkg::CTL_ENABLE_BIT])
		else $error("enable does not follow control");

	a_pin_free: assert property (@(posedge clk_i) disable iff (rst_i)
		control_q[ampctl_pkg::CTL_UNITY_BIT] |-> (analog_o.inverting_pin_release && analog_o.inverting_select == 9'h000))
		else $error("pin not released in unity gain");

	a_pin_kept: assert property (@(posedge clk_i) disable iff (rst_i)
		!control_q[ampctl_pkg::CTL_UNITY_BIT] |-> !analog_o.inverting_pin_release)
		else $error("pin released without unity gain");

	a_polarity_low: assert property (@(posedge clk_i) disable iff (rst_i)
		(!control_q[ampctl_pkg::CTL_POLARITY_BIT] && control_q[1:0] == 2'b01 && !src_raw) |-> analog_o.output_hiz)
		else $error("low level override missed");

	a_reserved_mode: assert property (@(posedge clk_i) disable iff (rst_i)
		control_q[1:0] == 2'b11 |-> !ovr_act)
		else $error("override in reserved mode");

	a_mode_none_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		control_q[1:0] == 2'b00 |-> !override_active_o)
		else $error("override flag in mode none");

	a_off_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		!control_q[ampctl_pkg::CTL_ENABLE_BIT] |-> !override_active_o)
		else $error("override flag while disabled");

	a_unity_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(!control_q[ampctl_pkg::CTL_UNITY_BIT] && control_q[1:0] != 2'b10) |-> !analog_o.unity_gain_switch)
		else $error("unity switch without cause");

	a_drive_on: assert property (@(posedge clk_i) disable iff (rst_i)
		(control_q[ampctl_pkg::CTL_ENABLE_BIT] && control_q[1:0] != 2'b01) |-> !analog_o.output_hiz)
		else $error("output off without cause");

	a_inv_code0: assert property (@(posedge clk_i) disable iff (rst_i)
		(!control_q[ampctl_pkg::CTL_UNITY_BIT] && inv_chan_q[3:0] == 4'h0) |-> analog_o.inverting_select == 9'h001)
		else $error("inverting pin 0 not selected");

	a_inv_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
		(INSTANCE != 3 && inv_chan_q[3:0] > ampctl_pkg::CH_LAST_LEGAL) |-> analog_o.inverting_select == 9'h000)
		else $error("switch closed on reserved code");

	a_inst3_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
		(INSTANCE == 3 && noninv_chan_q[3:0] == 4'h1) |-> analog_o.noninverting_select == 9'h000)
		else $error("switch closed on reduced map gap");

	a_noninv_code0: assert property (@(posedge clk_i) disable iff (rst_i)
		noninv_chan_q[3:0] == 4'h0 |-> analog_o.noninverting_select == 9'h001)
		else $error("noninverting pin 0 not selected");

	// ==========================================================
	// Override source picks at the group edges
	a_capture_first: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h00 |-> src_raw == src_i.capture_compare_output[0])
		else $error("capture source wrong");

	a_pwm_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h08 |-> src_raw == src_i.pulse_width_output[3])
		else $error("pulse width source wrong");

	a_pwm_last: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h0a |-> src_raw == src_i.pulse_width_output[5])
		else $error("last pulse width source wrong");

	a_pwm_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
		(ovr_source_q[4:0] == 5'h03 || ovr_source_q[4:0] == 5'h07 || ovr_source_q[4:0] == 5'h0b) |-> !src_raw)
		else $error("reserved source not low");

	a_cmp_first: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h0c |-> src_raw == src_i.synced_comparator_output[0])
		else $error("first comparator source wrong");

	a_cmp_last: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h11 |-> src_raw == src_i.synced_comparator_output[5])
		else $error("last comparator source wrong");

	a_cmp_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
		(ovr_source_q[4:0] == 5'h12 || ovr_source_q[4:0] == 5'h13) |-> !src_raw)
		else $error("reserved comparator code not low");

	a_cell_last: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h17 |-> src_raw == src_i.logic_cell_output[3])
		else $error("logic cell source wrong");

	a_gen_a_last: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] == 5'h1b |-> src_raw == src_i.complementary_generator_a[3])
		else $error("first generator source wrong");

	// Upper generator codes are reserved on the third instance
	a_gen_b_codes: assert property (@(posedge clk_i) disable iff (rst_i)
		ovr_source_q[4:0] >= ampctl_pkg::ORS_GEN_B |->
		src_raw == (INSTANCE != 3 && src_i.complementary_generator_b[ovr_source_q[1:0]]))
		else $error("second generator source wrong");

endmodule // ampctl_top

/* testbench/ampctl_src_model.sv */
// Behavioural model of the peripheral signals that feed the override source mux
`timescale 1ns/1ps
module ampctl_src_model (
	input  wire logic [4:0]             code_i,
	output ampctl_pkg::ampctl_sources_t src_o
);
	// ==========================================================
	// Source drive
	// Only the named signal is high, so a wrong pick reads low
	always_comb begin
		src_o = '0;
		case (code_i) inside
			[5'h00:5'h02]: src_o.capture_compare_output[code_i[1:0]] = 1'b1;
			[5'h04:5'h06]: src_o.pulse_width_output[code_i - 5'h04] = 1'b1;
			[5'h08:5'h0a]: src_o.pulse_width_output[code_i - 5'h05] = 1'b1;
			[5'h0c:5'h11]: src_o.synced_comparator_output[code_i - 5'h0c] = 1'b1;
			[5'h14:5'h17]: src_o.logic_cell_output[code_i[1:0]] = 1'b1;
			[5'h18:5'h1b]: src_o.complementary_generator_a[code_i[1:0]] = 1'b1;
			[5'h1c:5'h1f]: src_o.complementary_generator_b[code_i[1:0]] = 1'b1;
			default: ;
		endcase
	end
endmodule // ampctl_src_model

/* testbench/ampctl_top_tb.sv */
// Self-checking bench for the amplifier control block
`timescale 1ns/1ps
module ampctl_top_tb;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic        sleep_i = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [3:0]  adr     = 4'h0;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] dat     = 32'h0;
	logic [4:0]  code    = 5'h00;
	logic [31:0] rd_dat;
	logic        ack;
	logic        err;
	logic        act;
	logic [31:0] rd;
	logic        e;
	logic        srcv;
	logic        x;
	logic        x3;
	logic        act3;
	logic [7:0]  masks [4] = '{8'h97, 8'h1f, 8'h0f, 8'h0f};
	int          mismatches      = 0;
	int          samples_checked = 0;
	ampctl_pkg::ampctl_sources_t src;
	ampctl_pkg::ampctl_analog_t  ana;
	ampctl_pkg::ampctl_analog_t  ana3;

	// ==========================================================
	// Clock, design and source model
	always #4 clk_i = ~clk_i;
	ampctl_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd_dat), .wb_ack_o(ack),
		.wb_err_o(err), .src_i(src), .analog_o(ana), .override_active_o(act));
	// Third instance shares the bus; only its reduced maps are checked
	ampctl_top #(.INSTANCE(3)) u_dut3 (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(),
		.wb_ack_o(), .wb_err_o(), .src_i(src), .analog_o(ana3), .override_active_o(act3));
	ampctl_src_model u_src (.code_i(code), .src_o(src));

	// ==========================================================
	// Tasks
	// Compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	// One classic cycle; held until ack or err is sampled high
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s,
		output logic [31:0] r, output logic er);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= {3'h0, s};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		r = rd_dat;
		er = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) chk("bus answer", 1, 0);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("enable", 0, ana.enable);
		chk("hiz", 1, ana.output_hiz);
		// Reset values, then all ones to find the writable bits
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 4'(i * 4), 8'h00, 1'b1, rd, e);
			chk("reset value", 32'h0, rd);
			bus(1'b1, 4'(i * 4), 8'hff, 1'b1, rd, e);
			bus(1'b0, 4'(i * 4), 8'h00, 1'b1, rd, e);
			chk("masked value", {24'h0, masks[i]}, rd);
		end
		bus(1'b0, 4'h2, 8'h00, 1'b1, rd, e);
		chk("unmapped err", 1, e);
		// Low byte strobe off: the write must not land
		bus(1'b1, 4'h0, 8'h00, 1'b0, rd, e);
		bus(1'b0, 4'h0, 8'h00, 1'b1, rd, e);
		chk("strobe gate", 32'h97, rd);
		// Every channel code on both muxes, amplifier on
		bus(1'b1, 4'h0, 8'h80, 1'b1, rd, e);
		chk("enable on", 1, ana.enable);
		chk("drive on", 0, ana.output_hiz);
		for (int c = 0; c < 16; c++) begin
			bus(1'b1, 4'h8, 8'(c), 1'b1, rd, e);
			bus(1'b1, 4'hc, 8'(c), 1'b1, rd, e);
			@(negedge clk_i);
			chk("inv select", (c < 9) ? 32'(1 << c) : 32'h0, 32'(ana.inverting_select));
			chk("noninv select", (c < 9) ? 32'(1 << c) : 32'h0, 32'(ana.noninverting_select));
			chk("inv select 3", (c inside {0, 2, 4, 6, 7}) ? 32'(1 << c) : 32'h0, 32'(ana3.inverting_select));
		end
		bus(1'b1, 4'h8, 8'h00, 1'b1, rd, e);
		bus(1'b1, 4'h0, 8'h90, 1'b1, rd, e);
		@(negedge clk_i);
		chk("inv path open", 0, 32'(ana.inverting_select));
		chk("unity switch", 1, ana.unity_gain_switch);
		chk("pin release", 1, ana.inverting_pin_release);
		// Every source code, both polarities, all four modes; sleep in the upper half
		for (int c = 0; c < 32; c++) begin
			code <= 5'(c);
			sleep_i <= (c >= 16);
			srcv = !(c inside {3, 7, 11, 18, 19});
			bus(1'b1, 4'h4, 8'(c), 1'b1, rd, e);
			for (int p = 0; p < 2; p++) begin
				for (int m = 0; m < 4; m++) begin
					bus(1'b1, 4'h0, {4'h8, 1'b0, p[0], m[1:0]}, 1'b1, rd, e);
					@(negedge clk_i);
					x = (srcv == p[0]) && (m == 1 || m == 2);
					x3 = ((srcv && c < 28) == p[0]) && (m == 1 || m == 2);
					chk("override inst 3", x3, act3);
					chk("override", x, act);
					chk("tristate", x && m == 1, ana.output_hiz);
					chk("forced unity", x && m == 2, ana.unity_gain_switch);
				end
			end
		end
		results();
	end

	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		#200000;
		mismatches++;
		results();
	end
endmodule // ampctl_top_tb
